//--- core/lmcd_pkg.sv
// shared constants, encodings and carrier types for the lane mux control decoder
package lmcd_pkg;

  // ----------------------------------------------------------------
  // three-level pin encoding
  // ----------------------------------------------------------------
  localparam logic [1:0] TL_LOW = 2'h0;
  localparam logic [1:0] TL_HIGH = 2'h1;
  localparam logic [1:0] TL_FLOAT = 2'h2;

  // ----------------------------------------------------------------
  // register bus geometry and map (word indices; status also as byte address)
  // ----------------------------------------------------------------
  localparam int AW = 5;
  localparam int DW = 32;
  localparam int IW = 3;
  localparam int NWORDS = 5;
  localparam logic [IW-1:0] IDX_CTRL = 3'h0;
  localparam logic [IW-1:0] IDX_EQ_L0 = 3'h1;
  localparam logic [IW-1:0] IDX_EQ_L1 = 3'h2;
  localparam logic [IW-1:0] IDX_DE_L0 = 3'h3;
  localparam logic [IW-1:0] IDX_DE_L1 = 3'h4;
  localparam logic [IW-1:0] IDX_STATUS = 3'h5;
  localparam logic [AW-1:0] ADDR_STATUS = 5'h14;

  // ----------------------------------------------------------------
  // control word fields
  // ----------------------------------------------------------------
  localparam int CTRL_SWING_LSB = 0;
  localparam int CTRL_RATE_LSB = 2;
  localparam int CTRL_PD_LSB = 4;
  localparam int CTRL_THR_LSB = 8;
  localparam int THR_W = 4;
  // per-lane boost and emphasis words share one layout
  localparam int PORT_A_LSB = 0;
  localparam int PORT_B_LSB = 2;
  localparam int PORT_D_LSB = 4;

  // status word fields
  localparam int ST_MODE = 0;
  localparam int ST_ADDR_LSB = 1;
  localparam int ST_SWING_LSB = 5;
  localparam int ST_RATE_LSB = 7;
  localparam int ST_BCAST = 9;
  localparam int ST_PATH_LSB = 10;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [DW-1:0] CTRL_RST = 32'h0000_0008;
  localparam logic [DW-1:0] LANE_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // output carrier per lane
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] a_rx_boost;
    logic [1:0] b_rx_boost;
    logic [1:0] d_rx_boost;
    logic [1:0] a_tx_emphasis;
    logic [1:0] b_tx_emphasis;
    logic [1:0] d_tx_emphasis;
    logic a_input_sel;
    logic a_out_en;
    logic b_out_en;
    logic power_down;
  } lmcd_lane_cfg_t;

  // an unused fourth code is read as float: the pin is not driven hard
  function automatic logic [1:0] tl_level(input logic [1:0] code);
    tl_level = (code == TL_LOW || code == TL_HIGH) ? code : TL_FLOAT;
  endfunction

  // pulled-down pin: only a firm high reads as one
  function automatic logic pd_bit(input logic [1:0] code);
    pd_bit = (code == TL_HIGH);
  endfunction

endpackage

//--- core/lmcd_regfile.sv
// small register store with registered read port
`timescale 1ns/1ps
module lmcd_regfile (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_we,
  input wire logic [lmcd_pkg::IW-1:0] i_widx,
  input wire logic [lmcd_pkg::DW-1:0] i_wdata,
  input wire logic i_re,
  input wire logic i_rok,
  input wire logic [lmcd_pkg::IW-1:0] i_ridx,
  input wire logic [lmcd_pkg::DW-1:0] i_status,
  output logic [lmcd_pkg::DW-1:0] o_rdata,
  output logic [lmcd_pkg::NWORDS*lmcd_pkg::DW-1:0] o_words
);

  logic [lmcd_pkg::DW-1:0] word_q [lmcd_pkg::NWORDS];
  logic [lmcd_pkg::DW-1:0] rsel;
  logic [lmcd_pkg::DW-1:0] rdata_q;

  // ----------------------------------------------------------------
  // storage words
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < lmcd_pkg::NWORDS; g++) begin : g_word
      // control word resets to auto rate, lane words to lowest level
      always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          word_q[g] <= (g == 0) ? lmcd_pkg::CTRL_RST : lmcd_pkg::LANE_RST;
        end else if (i_we && i_widx == (lmcd_pkg::IW)'(g)) begin
          word_q[g] <= i_wdata;
        end
      end
      assign o_words[g*lmcd_pkg::DW +: lmcd_pkg::DW] = word_q[g];
    end
  endgenerate

  // ----------------------------------------------------------------
  // read select, zero for blocked or unmapped access
  // ----------------------------------------------------------------
  assign rsel = !i_rok ? '0 :
                (i_ridx == lmcd_pkg::IDX_STATUS) ? i_status :
                (i_ridx < lmcd_pkg::NWORDS) ? word_q[i_ridx] : '0;

  // read data held until the next read is taken
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_q <= '0;
    end else if (i_re) begin
      rdata_q <= rsel;
    end
  end

  assign o_rdata = rdata_q;

endmodule

//--- core/lmcd_top.sv
// lane mux control decoder: source select, strap decode and path control
`timescale 1ns/1ps
module lmcd_top (
  input wire logic i_clk,
  input wire logic i_arst_n,
  // register bus
  input wire logic [lmcd_pkg::AW-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [lmcd_pkg::DW-1:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [lmcd_pkg::DW-1:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // pins, each as a two-bit level code
  input wire logic [1:0] i_mgmt_mode_select,
  input wire logic [1:0] i_port_a_rx_boost,
  input wire logic [1:0] i_port_b_rx_boost,
  input wire logic [1:0] i_port_d_rx_boost,
  input wire logic [1:0] i_port_a_tx_emphasis,
  input wire logic [1:0] i_port_b_tx_emphasis,
  input wire logic [1:0] i_port_d_tx_emphasis,
  input wire logic [1:0] i_rate_select,
  input wire logic [1:0] i_dside_idle_control,
  input wire logic [1:0] i_switch_side_idle_control,
  input wire logic [1:0] i_broadcast_select,
  input wire logic [1:0] i_lane0_path_select,
  input wire logic [1:0] i_lane1_path_select,
  input wire logic [1:0] i_swing_code_bit0,
  input wire logic [1:0] i_swing_code_bit1,
  // management bus engine side
  input wire logic i_mgmt_sda_pull_low,
  output logic o_mgmt_bus_en,
  output logic o_mgmt_sda_rx,
  output logic o_mgmt_scl_rx,
  output logic o_mgmt_sda_o,
  output logic o_mgmt_sda_oe,
  output logic [3:0] o_mgmt_target_addr,
  // decoded settings
  output lmcd_pkg::lmcd_lane_cfg_t o_lane0_cfg,
  output lmcd_pkg::lmcd_lane_cfg_t o_lane1_cfg,
  output logic [1:0] o_swing_code,
  output logic [1:0] o_rate_mode,
  output logic [1:0] o_dside_idle_mode,
  output logic [1:0] o_switch_side_idle_mode,
  output logic o_idle_thr_from_reg,
  output logic [lmcd_pkg::THR_W-1:0] o_idle_thr_code
);

  // ----------------------------------------------------------------
  // mode and pin decode
  // ----------------------------------------------------------------
  wire mode_mgmt;
  wire bcast;
  wire [1:0] path_sel;
  wire [1:0] pin_swing;
  wire [1:0] pin_rate;

  // mode pin is pulled down, so an open pin means pin mode
  assign mode_mgmt = lmcd_pkg::pd_bit(i_mgmt_mode_select);
  assign bcast = lmcd_pkg::pd_bit(i_broadcast_select);
  assign path_sel[0] = lmcd_pkg::pd_bit(i_lane0_path_select);
  assign path_sel[1] = lmcd_pkg::pd_bit(i_lane1_path_select);
  assign pin_swing = {lmcd_pkg::pd_bit(i_swing_code_bit1),
                      lmcd_pkg::pd_bit(i_swing_code_bit0)};
  // three-level pins keep the float state as its own code
  assign pin_rate = lmcd_pkg::tl_level(i_rate_select);

  // idle controls are honoured in both modes
  assign o_dside_idle_mode = lmcd_pkg::tl_level(i_dside_idle_control);
  assign o_switch_side_idle_mode = lmcd_pkg::tl_level(i_switch_side_idle_control);

  // ----------------------------------------------------------------
  // shared pins as management bus and address straps
  // ----------------------------------------------------------------
  // the bus engine sees an idle-high line outside management mode
  assign o_mgmt_bus_en = mode_mgmt;
  assign o_mgmt_scl_rx = mode_mgmt ? lmcd_pkg::pd_bit(i_port_b_tx_emphasis) : 1'b1;
  assign o_mgmt_sda_rx = mode_mgmt ? lmcd_pkg::pd_bit(i_port_b_rx_boost) : 1'b1;
  assign o_mgmt_sda_o = 1'b0; // open drain: only ever pulls low
  assign o_mgmt_sda_oe = mode_mgmt & i_mgmt_sda_pull_low;
  // address straps share the A and D strap pins, pulled down when open
  assign o_mgmt_target_addr = mode_mgmt ?
    {lmcd_pkg::pd_bit(i_port_d_tx_emphasis), lmcd_pkg::pd_bit(i_port_d_rx_boost),
     lmcd_pkg::pd_bit(i_port_a_tx_emphasis), lmcd_pkg::pd_bit(i_port_a_rx_boost)}
    : 4'h0;

  // ----------------------------------------------------------------
  // register bus slave
  // ----------------------------------------------------------------
  wire bus_req;
  wire [lmcd_pkg::IW-1:0] bus_idx;
  wire bus_aligned;
  wire bus_mapped;
  wire bus_writable;
  wire bus_we;
  wire bus_re;
  wire [lmcd_pkg::DW-1:0] old_word;
  wire [lmcd_pkg::DW-1:0] merged_wdata;
  wire [lmcd_pkg::DW-1:0] status_word;
  wire [lmcd_pkg::NWORDS*lmcd_pkg::DW-1:0] words;
  logic ack_q;
  logic ack_d;

  // every access waits exactly one cycle, then completes
  assign bus_req = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = bus_req & ~ack_q;
  assign ack_d = bus_req & ~ack_q;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= ack_d;
    end
  end

  // address decode
  assign bus_idx = i_avs_address[lmcd_pkg::AW-1:2];
  assign bus_aligned = (i_avs_address[1:0] == 2'h0);
  assign bus_mapped = bus_aligned && (i_avs_address <= lmcd_pkg::ADDR_STATUS);
  assign bus_writable = bus_aligned && (bus_idx < lmcd_pkg::NWORDS);

  // pin mode locks the registers: writes dropped, reads return zero
  assign bus_we = i_avs_write & ack_q & mode_mgmt & bus_writable;
  assign bus_re = i_avs_read & ~ack_q;

  // byte lanes not enabled keep their old contents
  assign old_word = bus_writable ?
    words[bus_idx*lmcd_pkg::DW +: lmcd_pkg::DW] : '0;
  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_lane
      assign merged_wdata[b*8 +: 8] = i_avs_byteenable[b] ?
        i_avs_writedata[b*8 +: 8] : old_word[b*8 +: 8];
    end
  endgenerate

  lmcd_regfile u_regs (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_we(bus_we),
    .i_widx(bus_idx),
    .i_wdata(merged_wdata),
    .i_re(bus_re),
    .i_rok(mode_mgmt & bus_mapped),
    .i_ridx(bus_idx),
    .i_status(status_word),
    .o_rdata(o_avs_readdata),
    .o_words(words)
  );

  // ----------------------------------------------------------------
  // register fields
  // ----------------------------------------------------------------
  wire [lmcd_pkg::DW-1:0] ctrl_w;
  wire [lmcd_pkg::DW-1:0] eq_w [2];
  wire [lmcd_pkg::DW-1:0] de_w [2];

  assign ctrl_w = words[lmcd_pkg::IDX_CTRL*lmcd_pkg::DW +: lmcd_pkg::DW];
  assign eq_w[0] = words[lmcd_pkg::IDX_EQ_L0*lmcd_pkg::DW +: lmcd_pkg::DW];
  assign eq_w[1] = words[lmcd_pkg::IDX_EQ_L1*lmcd_pkg::DW +: lmcd_pkg::DW];
  assign de_w[0] = words[lmcd_pkg::IDX_DE_L0*lmcd_pkg::DW +: lmcd_pkg::DW];
  assign de_w[1] = words[lmcd_pkg::IDX_DE_L1*lmcd_pkg::DW +: lmcd_pkg::DW];

  // ----------------------------------------------------------------
  // global settings: source chosen by mode, no pipeline stage
  // ----------------------------------------------------------------
  // a register source change takes effect the cycle the mode pin moves
  assign o_swing_code = mode_mgmt ?
    ctrl_w[lmcd_pkg::CTRL_SWING_LSB +: 2] : pin_swing;
  assign o_rate_mode = mode_mgmt ?
    lmcd_pkg::tl_level(ctrl_w[lmcd_pkg::CTRL_RATE_LSB +: 2]) : pin_rate;
  // threshold code only counts in management mode; else the analog pin rules
  assign o_idle_thr_from_reg = mode_mgmt;
  assign o_idle_thr_code = mode_mgmt ?
    ctrl_w[lmcd_pkg::CTRL_THR_LSB +: lmcd_pkg::THR_W] : '0;

  // ----------------------------------------------------------------
  // per-lane settings
  // ----------------------------------------------------------------
  lmcd_pkg::lmcd_lane_cfg_t lane_cfg [2];
  genvar l;
  generate
    for (l = 0; l < 2; l++) begin : g_cfg
      // straps drive both lanes alike; registers give each lane its own
      assign lane_cfg[l].a_rx_boost = mode_mgmt ?
        lmcd_pkg::tl_level(eq_w[l][lmcd_pkg::PORT_A_LSB +: 2]) :
        lmcd_pkg::tl_level(i_port_a_rx_boost);
      assign lane_cfg[l].b_rx_boost = mode_mgmt ?
        lmcd_pkg::tl_level(eq_w[l][lmcd_pkg::PORT_B_LSB +: 2]) :
        lmcd_pkg::tl_level(i_port_b_rx_boost);
      assign lane_cfg[l].d_rx_boost = mode_mgmt ?
        lmcd_pkg::tl_level(eq_w[l][lmcd_pkg::PORT_D_LSB +: 2]) :
        lmcd_pkg::tl_level(i_port_d_rx_boost);
      assign lane_cfg[l].a_tx_emphasis = mode_mgmt ?
        lmcd_pkg::tl_level(de_w[l][lmcd_pkg::PORT_A_LSB +: 2]) :
        lmcd_pkg::tl_level(i_port_a_tx_emphasis);
      assign lane_cfg[l].b_tx_emphasis = mode_mgmt ?
        lmcd_pkg::tl_level(de_w[l][lmcd_pkg::PORT_B_LSB +: 2]) :
        lmcd_pkg::tl_level(i_port_b_tx_emphasis);
      assign lane_cfg[l].d_tx_emphasis = mode_mgmt ?
        lmcd_pkg::tl_level(de_w[l][lmcd_pkg::PORT_D_LSB +: 2]) :
        lmcd_pkg::tl_level(i_port_d_tx_emphasis);
      // path: one picks A, zero picks B
      assign lane_cfg[l].a_input_sel = path_sel[l];
      assign lane_cfg[l].a_out_en = bcast | path_sel[l];
      assign lane_cfg[l].b_out_en = bcast | ~path_sel[l];
      assign lane_cfg[l].power_down = mode_mgmt & ctrl_w[lmcd_pkg::CTRL_PD_LSB + l];
    end
  endgenerate

  assign o_lane0_cfg = lane_cfg[0];
  assign o_lane1_cfg = lane_cfg[1];

  // ----------------------------------------------------------------
  // status word: live view of the decoded state
  // ----------------------------------------------------------------
  assign status_word = {{(lmcd_pkg::DW - lmcd_pkg::ST_PATH_LSB - 2){1'b0}},
                        path_sel,
                        bcast,
                        o_rate_mode,
                        o_swing_code,
                        o_mgmt_target_addr,
                        mode_mgmt};

endmodule

//--- verification/lmcd_board_model.sv
// board side model: strap ties and open pins as seen at the control pins
`timescale 1ns/1ps
module lmcd_board_model (
  input wire logic [29:0] i_tie,
  output logic [29:0] o_code
);
  // ------------------------------------------------------------
  // pin levels
  // ------------------------------------------------------------
  // per pin: 00 tied low, 01 tied high, else left open (third state)
  always_comb begin
    for (int p = 0; p < 15; p++) begin
      o_code[2*p +: 2] = (i_tie[2*p +: 2] == 2'h0) ? 2'h0 : 2'h2;
      if (i_tie[2*p +: 2] == 2'h1) begin
        o_code[2*p +: 2] = 2'h1;
      end
    end
  end
endmodule

//--- verification/lmcd_checker.sv
// concurrent checks on the lane mux control decoder ports
`timescale 1ns/1ps
module lmcd_checker (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic o_avs_waitrequest,
  input wire logic [1:0] i_mgmt_mode_select,
  input wire logic [1:0] i_port_a_rx_boost,
  input wire logic [1:0] i_port_d_tx_emphasis,
  input wire logic [1:0] i_rate_select,
  input wire logic [1:0] i_switch_side_idle_control,
  input wire logic [1:0] i_broadcast_select,
  input wire logic [1:0] i_lane0_path_select,
  input wire logic [1:0] i_swing_code_bit0,
  input wire logic [1:0] i_swing_code_bit1,
  input wire logic i_mgmt_sda_pull_low,
  input wire logic o_mgmt_bus_en,
  input wire logic o_mgmt_sda_oe,
  input wire logic [3:0] o_mgmt_target_addr,
  input wire lmcd_pkg::lmcd_lane_cfg_t o_lane0_cfg,
  input wire logic [1:0] o_swing_code,
  input wire logic [1:0] o_rate_mode,
  input wire logic [1:0] o_switch_side_idle_mode
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  // ------------------------------------------------------------
  // expected levels
  // ------------------------------------------------------------
  // the unused fourth code reads as open, so it must not alias high
  wire mgmt_on = (i_mgmt_mode_select == 2'h1);
  wire lane0_path_select = (i_lane0_path_select == 2'h1);
  wire bcast = (i_broadcast_select == 2'h1);
  wire [1:0] a_lvl = (i_port_a_rx_boost == 2'h3) ? 2'h2 : i_port_a_rx_boost;
  wire [1:0] r_lvl = (i_rate_select == 2'h3) ? 2'h2 : i_rate_select;
  wire [1:0] s_lvl = (i_switch_side_idle_control == 2'h3) ? 2'h2 : i_switch_side_idle_control;
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  chk_bus_gate: assert property (o_mgmt_bus_en == mgmt_on)
    else $error("bus enable does not follow mode pin");
  chk_sda_drive: assert property (o_mgmt_sda_oe == (mgmt_on && i_mgmt_sda_pull_low))
    else $error("data line enable wrong");
  chk_addr_straps: assert property (
    o_mgmt_target_addr[3] == (mgmt_on && i_port_d_tx_emphasis == 2'h1)
    && o_mgmt_target_addr[0] == (mgmt_on && i_port_a_rx_boost == 2'h1))
    else $error("target address straps wrong");
  chk_bcast_both: assert property (
    bcast |-> o_lane0_cfg.a_out_en && o_lane0_cfg.b_out_en)
    else $error("broadcast does not enable both outputs");
  chk_sel_route: assert property (
    !bcast |-> o_lane0_cfg.a_out_en == lane0_path_select && o_lane0_cfg.b_out_en == !lane0_path_select)
    else $error("unselected output not disabled");
  chk_path_pick: assert property (o_lane0_cfg.a_input_sel == lane0_path_select)
    else $error("path select routes wrong input");
  chk_strap_boost: assert property (!mgmt_on |-> o_lane0_cfg.a_rx_boost == a_lvl)
    else $error("boost strap not decoded");
  chk_rate_pins: assert property (!mgmt_on |-> o_rate_mode == r_lvl)
    else $error("rate strap not decoded");
  chk_idle_pins: assert property (o_switch_side_idle_mode == s_lvl)
    else $error("switch side idle mode wrong");
  chk_swing_pins: assert property (
    !mgmt_on |-> o_swing_code == {i_swing_code_bit1 == 2'h1, i_swing_code_bit0 == 2'h1})
    else $error("swing code from pins wrong");
  chk_wait_once: assert property (
    (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("bus access held more than one wait cycle");
  // main scenarios seen
  cov_mgmt_write: cover property (mgmt_on && i_avs_write && !o_avs_waitrequest);
  cov_bcast: cover property (bcast && lane0_path_select);
  cov_forced_idle: cover property (o_switch_side_idle_mode == 2'h1);
endmodule

bind lmcd_top lmcd_checker u_chk (.*);

//--- verification/lane_mux_control_decode_tb_top.sv
// self-checking bench for the lane mux control decoder
`timescale 1ns/1ps
module lane_mux_control_decode_tb_top;
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic [4:0] adr = 5'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] q;
  logic pull = 1'b0;
  logic [3:0] be = 4'hF;
  logic [29:0] tie = {15{2'h2}};
  wire [29:0] code;
  wire [31:0] rdat;
  wire wreq, bus_en, sda_rx, scl_rx, sda_o, sda_oe, thr_reg;
  wire [3:0] taddr, thr;
  wire [1:0] swing, rate, didle, sidle;
  wire lmcd_pkg::lmcd_lane_cfg_t l0, l1;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  // ------------------------------------------------------------
  // clock, board and design
  // ------------------------------------------------------------
  always #2.5 i_clk = ~i_clk;
  lmcd_board_model u_board (.i_tie(tie), .o_code(code));
  lmcd_top dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(be),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .i_mgmt_mode_select(code[1:0]),
    .i_port_a_rx_boost(code[3:2]), .i_port_b_rx_boost(code[5:4]),
    .i_port_d_rx_boost(code[7:6]), .i_port_a_tx_emphasis(code[9:8]),
    .i_port_b_tx_emphasis(code[11:10]), .i_port_d_tx_emphasis(code[13:12]),
    .i_rate_select(code[15:14]), .i_dside_idle_control(code[17:16]),
    .i_switch_side_idle_control(code[19:18]), .i_broadcast_select(code[21:20]),
    .i_lane0_path_select(code[23:22]), .i_lane1_path_select(code[25:24]),
    .i_swing_code_bit0(code[27:26]), .i_swing_code_bit1(code[29:28]),
    .i_mgmt_sda_pull_low(pull), .o_mgmt_bus_en(bus_en), .o_mgmt_sda_rx(sda_rx),
    .o_mgmt_scl_rx(scl_rx), .o_mgmt_sda_o(sda_o), .o_mgmt_sda_oe(sda_oe),
    .o_mgmt_target_addr(taddr), .o_lane0_cfg(l0), .o_lane1_cfg(l1), .o_swing_code(swing),
    .o_rate_mode(rate), .o_dside_idle_mode(didle), .o_switch_side_idle_mode(sidle),
    .o_idle_thr_from_reg(thr_reg), .o_idle_thr_code(thr));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one access: hold everything until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    adr <= a;
    wr <= w;
    rd <= !w;
    wdat <= d;
    // read just after the edge, so the values are those that edge sampled
    do begin
      @(posedge i_clk);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    if (wreq !== 1'b0) begin
      error_cnt++;
      $display("MISMATCH t=%0t access never completed", $time);
    end
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  // bench hang guard, far above the roughly 60 cycles needed
  always @(posedge i_clk) begin
    cyc++;
    if (cyc > 5000) begin
      error_cnt++;
      close_out();
    end
  end
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (3) @(posedge i_clk);
    i_arst_n <= 1'b1;
    // pin mode: every three-level strap at low, high and open
    for (int c = 0; c < 3; c++) begin
      @(posedge i_clk);
      for (int p = 1; p < 10; p++) tie[2*p +: 2] <= c[1:0];
      @(negedge i_clk);
      chk(l0[15:4], {6{c[1:0]}});
      chk(l1[15:4], {6{c[1:0]}});
      chk({rate, didle, sidle}, {3{c[1:0]}});
      chk({bus_en, taddr, l0.power_down}, 6'h00);
    end
    // swing code, an open bit must read low
    for (int s = 0; s < 4; s++) begin
      @(posedge i_clk);
      tie[27:26] <= s[0] ? 2'h1 : 2'h2;
      tie[29:28] <= s[1] ? 2'h1 : 2'h2;
      @(negedge i_clk);
      chk(swing, s[1:0]);
    end
    // broadcast and both path selects, every combination
    for (int v = 0; v < 8; v++) begin
      @(posedge i_clk);
      tie[21:20] <= {1'b0, v[2]};
      tie[23:22] <= {1'b0, v[0]};
      tie[25:24] <= {1'b0, v[1]};
      @(negedge i_clk);
      chk({l0.a_input_sel, l0.a_out_en, l0.b_out_en},
        {v[0], v[2] | v[0], v[2] | !v[0]});
      chk({l1.a_input_sel, l1.a_out_en, l1.b_out_en},
        {v[1], v[2] | v[1], v[2] | !v[1]});
    end
    // pin mode blocks the registers
    bus(1'b1, 5'h00, 32'h0000_0A14);
    bus(1'b0, 5'h00, 32'h0);
    chk(q, 32'h0);
    chk(swing, 2'h3);
    // management mode: shared pins become bus lines and address
    @(posedge i_clk);
    tie[1:0] <= 2'h1;
    tie[3:2] <= 2'h1;
    tie[5:4] <= 2'h0;
    tie[7:6] <= 2'h1;
    tie[9:8] <= 2'h0;
    tie[11:10] <= 2'h1;
    tie[13:12] <= 2'h2;
    @(negedge i_clk);
    chk({bus_en, sda_rx, scl_rx, sda_o, sda_oe}, 5'h14);
    chk(taddr, 4'h5);
    @(posedge i_clk);
    pull <= 1'b1;
    @(negedge i_clk);
    chk(sda_oe, 1'b1);
    bus(1'b0, 5'h00, 32'h0);
    chk(q, 32'h0000_0008);
    chk({swing, rate}, 4'h2);
    // swing 1000 mV chosen so the emphasis levels hold
    bus(1'b1, 5'h00, 32'h0000_0A16);
    @(negedge i_clk);
    chk({swing, rate, l0.power_down, l1.power_down, thr_reg, thr}, 11'h4DA);
    bus(1'b1, 5'h04, 32'h0000_0016);
    bus(1'b1, 5'h08, 32'h0000_0021);
    bus(1'b1, 5'h0C, 32'h0000_0009);
    bus(1'b1, 5'h10, 32'h0000_0012);
    @(negedge i_clk);
    chk(l0[15:4], 12'h958);
    chk(l1[15:4], 12'h4A1);
    bus(1'b0, 5'h04, 32'h0);
    chk(q, 32'h0000_0016);
    // only byte one enabled: the other bytes keep their contents
    be <= 4'h2;
    bus(1'b1, 5'h04, 32'hFFFF_FF00);
    be <= 4'hF;
    bus(1'b0, 5'h04, 32'h0);
    chk(q, 32'h0000_FF16);
    bus(1'b0, 5'h18, 32'h0);
    chk(q, 32'h0);
    // status: live view of mode, address, swing, rate, broadcast and paths
    bus(1'b0, 5'h14, 32'h0);
    chk(q, 32'h0000_0ECB);
    // back to pin mode: straps rule again at once
    @(posedge i_clk);
    tie[1:0] <= 2'h0;
    @(negedge i_clk);
    chk(l0[15:4], 12'h446);
    chk({swing, bus_en, taddr}, 7'h60);
    bus(1'b0, 5'h00, 32'h0);
    chk(q, 32'h0);
    close_out();
  end
endmodule
